// file: rtl/bsc_pin_drive.sv
// bsc_pin_drive: system-clock side of the output boundary cells.
// assumes i_word holds still for several i_clk cycles after i_toggle flips.
`timescale 1ns/100ps
module bsc_pin_drive
    import bsc_pkg::*;
#(
    parameter int N_OUT = BSC_N_OUT_DEF
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_drive,
    input wire logic i_toggle,
    input wire logic [N_OUT-1:0] i_word,
    input wire logic [N_OUT-1:0] i_core_out,
    output logic [N_OUT-1:0] o_pin_out
);
    typedef struct packed {
        logic tog_seen;
        logic [N_OUT-1:0] word;
        logic [N_OUT-1:0] pins;
    } bsc_pin_state_type;

    bsc_pin_state_type s_q, s_d;
    logic [1:0] ctl_s;
    logic new_word;

    bsc_sync #(.W(2)) u_ctl_sync (
        .i_clk(i_clk),
        .i_rst(i_sys_rst),
        .i_d({i_drive, i_toggle}),
        .o_q(ctl_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // toggle handshake: word is taken only after the flip is seen, so it
    // has settled; a faster update rate than 3 i_clk per edge would tear it
    assign new_word = ctl_s[0] ^ s_q.tog_seen;

    always_comb begin
        s_d = s_q;
        s_d.tog_seen = ctl_s[0];
        if (new_word) begin
            s_d.word = i_word;
        end
        s_d.pins = ctl_s[1] ? s_q.word : i_core_out; // see R3, see R6
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_pin_out = s_q.pins;

    ////////////////////////////////////////////////////////////////////////
    pin_word_a: assert property ( // see R3
        @(posedge i_clk) disable iff (i_sys_rst)
        new_word |=> s_q.word == $past(i_word))
        else $error("boundary word not taken on toggle");

    pin_drive_a: assert property ( // see R3
        @(posedge i_clk) disable iff (i_sys_rst)
        ctl_s[1] |=> o_pin_out == $past(s_q.word))
        else $error("pins not driven from boundary cells");
endmodule // bsc_pin_drive

// file: rtl/bsc_pkg.sv
// bsc_pkg: constants, tap state codes and helpers for the scan port.
// assumes nothing beyond a tool that reads systemverilog packages.
package bsc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // instruction register
    localparam int BSC_IR_W = 4;
    localparam logic [3:0] BSC_IR_EXTEST = 4'h0;
    localparam logic [3:0] BSC_IR_SAMPLE = 4'h1;
    localparam logic [3:0] BSC_IR_IDCODE = 4'h2;
    localparam logic [3:0] BSC_IR_CLAMP = 4'h3;
    localparam logic [3:0] BSC_IR_BYPASS = 4'hf;
    localparam logic [3:0] BSC_IR_CAPTURE = 4'h1;

    ////////////////////////////////////////////////////////////////////////
    // identification word layout, default field values (arbitrary) and default pin counts
    localparam int BSC_ID_W = 32;
    localparam int BSC_ID_VER_LSB = 28;
    localparam int BSC_ID_PART_LSB = 12;
    localparam int BSC_ID_MAN_LSB = 1;
    localparam logic [3:0] BSC_ID_VER_DEF = 4'h1;
    localparam logic [15:0] BSC_ID_PART_DEF = 16'h0001;
    localparam logic [10:0] BSC_ID_MAN_DEF = 11'h001;
    localparam int BSC_N_IN_DEF = 8;
    localparam int BSC_N_OUT_DEF = 8;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        ST_EX2_DR = 4'h0, ST_EX1_DR = 4'h1, ST_SH_DR = 4'h2,
        ST_PAUSE_DR = 4'h3, ST_SEL_IR = 4'h4, ST_UPD_DR = 4'h5,
        ST_CAP_DR = 4'h6, ST_SEL_DR = 4'h7, ST_EX2_IR = 4'h8,
        ST_EX1_IR = 4'h9, ST_SH_IR = 4'ha, ST_PAUSE_IR = 4'hb,
        ST_RTI = 4'hc, ST_UPD_IR = 4'hd, ST_CAP_IR = 4'he, ST_TLR = 4'hf
    } bsc_tap_state_type;

    // serial output carried as one unit, clocked on the falling edge
    typedef struct packed {
        logic data;
        logic en;
    } bsc_tdo_type;

    function automatic bsc_tap_state_type bsc_next_state(
        input bsc_tap_state_type st, input logic tms);
        bsc_tap_state_type n;
        n = st;
        unique case (st)
            ST_TLR: n = tms ? ST_TLR : ST_RTI;
            ST_RTI, ST_UPD_DR, ST_UPD_IR: n = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR, ST_SH_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: n = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: n = tms ? ST_EX2_DR : ST_PAUSE_DR;
            ST_EX2_DR: n = tms ? ST_UPD_DR : ST_SH_DR;
            ST_SEL_IR: n = tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR, ST_SH_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: n = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: n = tms ? ST_EX2_IR : ST_PAUSE_IR;
            ST_EX2_IR: n = tms ? ST_UPD_IR : ST_SH_IR;
        endcase
        return n;
    endfunction

    function automatic logic bsc_is_shift(input bsc_tap_state_type st);
        return (st == ST_SH_DR) || (st == ST_SH_IR);
    endfunction

    function automatic logic bsc_uses_bsr(input logic [3:0] ir);
        return (ir == BSC_IR_EXTEST) || (ir == BSC_IR_SAMPLE);
    endfunction

    function automatic logic bsc_drives_pins(input logic [3:0] ir);
        return (ir == BSC_IR_EXTEST) || (ir == BSC_IR_CLAMP);
    endfunction

endpackage

// file: rtl/bsc_sync.sv
// bsc_sync: two-flop level synchroniser, any width.
// assumes each bit is a level that changes slowly against i_clk.
`timescale 1ns/100ps
module bsc_sync
    import bsc_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } bsc_sync_state_type;

    bsc_sync_state_type s_q, s_d;

    // the first stage feeds the second stage only
    always_comb begin
        s_d.meta = i_d;
        s_d.q = s_q.meta;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_q = s_q.q;
endmodule // bsc_sync

// file: rtl/bsc_tap.sv
// bsc_tap: test access port with instruction, bypass, id and boundary
// registers, driving the output pads through the system clock domain.
// assumes i_tck comes from the board tester and may stop between scans.
//
// What this block does
// R1 - five dedicated test pins: mode select, clock, reset, data in, out.
// R2 - bypass puts a single flop between data in and data out.
// R3 - extest lets boundary cells drive pins and observe pins.
// R4 - sample captures pin states while the chip keeps working.
// R5 - sample lets shifted data preload the boundary output latches.
// R6 - clamp uses bypass path while boundary cells keep driving pins.
// R7 - 32-bit id register with manufacturer, part and version fields.
// R8 - idcode instruction puts id register between data in and out.
// R9 - capture-dr loads the fixed id; shift moves it out.
// R10 - id bit 31 sits nearest data in; bit 0 shifts out first.
// R11 - test reset low forces test-logic-reset at once, no clock needed.
// R12 - entering test-logic-reset loads the idcode instruction at once on test reset, else on the first tck edge spent there.
// R13 - board keeps the port in test-logic-reset during normal use.
// R14 - sample mode and data in on rising, change data out on falling.
`timescale 1ns/100ps
module bsc_tap
    import bsc_pkg::*;
#(
    parameter int N_IN = BSC_N_IN_DEF,
    parameter int N_OUT = BSC_N_OUT_DEF,
    parameter logic [3:0] ID_VER = BSC_ID_VER_DEF,
    parameter logic [15:0] ID_PART = BSC_ID_PART_DEF,
    parameter logic [10:0] ID_MAN = BSC_ID_MAN_DEF
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_tck,
    input wire logic i_trst_n,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_en,
    input wire logic [N_IN-1:0] i_pin_in,
    input wire logic [N_OUT-1:0] i_core_out,
    output logic [N_OUT-1:0] o_pin_out
);
    localparam int BW = N_IN + N_OUT;

    // output cells sit nearest data out, input cells nearest data in
    typedef struct packed {
        bsc_tap_state_type st;
        logic [BSC_IR_W-1:0] ir;
        logic [BSC_IR_W-1:0] ir_sh;
        logic bp;
        logic [BSC_ID_W-1:0] id_sh;
        logic [BW-1:0] bsr_sh;
        logic [N_OUT-1:0] upd;
        logic upd_tog;
        logic drive;
    } bsc_tap_reg_type;

    localparam bsc_tap_reg_type TAP_RST = '{
        st: ST_TLR,
        ir: BSC_IR_IDCODE,
        ir_sh: 4'h0,
        bp: 1'b0,
        id_sh: 32'h0000_0000,
        bsr_sh: '0,
        upd: '0,
        upd_tog: 1'b0,
        drive: 1'b0
    };

    bsc_tap_reg_type s_q, s_d;
    bsc_tdo_type t_q, t_d;
    logic tap_rst;
    logic [BW-1:0] pins_s;
    logic [BSC_ID_W-1:0] id_word;

    ////////////////////////////////////////////////////////////////////////
    // fixed component code; bit 0 is always one so a tester can tell an
    // id register from a one-bit bypass stage
    function automatic logic [BSC_ID_W-1:0] bsc_make_id(
        input logic [3:0] ver, input logic [15:0] part,
        input logic [10:0] man);
        logic [BSC_ID_W-1:0] w;
        w = '0;
        w[BSC_ID_VER_LSB +: 4] = ver;
        w[BSC_ID_PART_LSB +: 16] = part;
        w[BSC_ID_MAN_LSB +: 11] = man;
        w[0] = 1'b1;
        return w;
    endfunction

    assign id_word = bsc_make_id(ID_VER, ID_PART, ID_MAN); // see R7
    assign tap_rst = ~i_trst_n;

    ////////////////////////////////////////////////////////////////////////
    // pads and the driven outputs cross into the test clock domain; an
    // observed pad may be up to two tck periods old
    bsc_sync #(.W(BW)) u_pin_sync (
        .i_clk(i_tck),
        .i_rst(tap_rst),
        .i_d({i_pin_in, o_pin_out}),
        .o_q(pins_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // controller and data registers, all moved on the rising edge
    always_comb begin
        s_d = s_q;
        s_d.st = bsc_next_state(s_q.st, i_tms); // see R14
        unique case (s_q.st)
            ST_TLR: begin
                s_d.ir = BSC_IR_IDCODE; // see R12
            end
            ST_CAP_IR: begin
                s_d.ir_sh = BSC_IR_CAPTURE;
            end
            ST_SH_IR: begin
                s_d.ir_sh = {i_tdi, s_q.ir_sh[BSC_IR_W-1:1]};
            end
            ST_UPD_IR: begin
                s_d.ir = s_q.ir_sh;
            end
            ST_CAP_DR: begin
                s_d.bp = 1'b0;
                if (s_q.ir == BSC_IR_IDCODE) begin
                    s_d.id_sh = id_word; // see R9
                end
                if (bsc_uses_bsr(s_q.ir)) begin
                    s_d.bsr_sh = pins_s; // see R3, see R4
                end
            end
            ST_SH_DR: begin
                if (s_q.ir == BSC_IR_IDCODE) begin
                    // see R8, see R10
                    s_d.id_sh = {i_tdi, s_q.id_sh[BSC_ID_W-1:1]};
                end else if (bsc_uses_bsr(s_q.ir)) begin
                    s_d.bsr_sh = {i_tdi, s_q.bsr_sh[BW-1:1]};
                end else begin
                    s_d.bp = i_tdi; // see R2, see R6
                end
            end
            ST_UPD_DR: begin
                if (bsc_uses_bsr(s_q.ir)) begin
                    s_d.upd = s_q.bsr_sh[N_OUT-1:0]; // see R3, see R5
                    s_d.upd_tog = ~s_q.upd_tog;
                end
            end
            ST_RTI, ST_SEL_DR, ST_EX1_DR, ST_PAUSE_DR, ST_EX2_DR,
            ST_SEL_IR, ST_EX1_IR, ST_PAUSE_IR, ST_EX2_IR: begin
            end
        endcase
        // pads stay functional under sample, so the chip keeps running
        s_d.drive = bsc_drives_pins(s_d.ir); // see R3, see R4, see R6
    end

    // test reset acts without a clock edge
    always_ff @(posedge i_tck or negedge i_trst_n) begin // see R11
        if (!i_trst_n) begin
            s_q <= TAP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial output, changed on the falling edge so the tester samples a
    // settled value on its next rising edge
    always_comb begin
        t_d.en = bsc_is_shift(s_q.st); // see R1
        if (s_q.st == ST_SH_IR) begin
            t_d.data = s_q.ir_sh[0];
        end else if (s_q.ir == BSC_IR_IDCODE) begin
            t_d.data = s_q.id_sh[0]; // see R10
        end else if (bsc_uses_bsr(s_q.ir)) begin
            t_d.data = s_q.bsr_sh[0];
        end else begin
            t_d.data = s_q.bp; // see R2, see R6
        end
    end

    always_ff @(negedge i_tck or negedge i_trst_n) begin // see R14
        if (!i_trst_n) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    assign o_tdo = t_q.data;
    assign o_tdo_en = t_q.en;

    ////////////////////////////////////////////////////////////////////////
    // output pads live in the system clock domain
    bsc_pin_drive #(.N_OUT(N_OUT)) u_pin_drive (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_drive(s_q.drive),
        .i_toggle(s_q.upd_tog),
        .i_word(s_q.upd),
        .i_core_out(i_core_out),
        .o_pin_out(o_pin_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks on the test clock domain
    default clocking tck_cb @(posedge i_tck);
    endclocking
    default disable iff (!i_trst_n);

    sequence tms_five;
        i_tms [*5];
    endsequence

    sequence id_captured;
        (s_q.st == ST_CAP_DR) && (s_q.ir == BSC_IR_IDCODE);
    endsequence

    sequence bypass_shift;
        (s_q.st == ST_SH_DR) && !bsc_uses_bsr(s_q.ir)
            && (s_q.ir != BSC_IR_IDCODE);
    endsequence

    tdo_enable_a: assert property ( // see R1
        o_tdo_en == bsc_is_shift(s_q.st))
        else $error("data out enable outside shift states");

    bypass_path_a: assert property ( // see R2
        bypass_shift |=> o_tdo == $past(i_tdi))
        else $error("bypass path not one stage long");

    extest_drive_a: assert property ( // see R3
        (s_q.ir == BSC_IR_EXTEST) |-> s_q.drive)
        else $error("extest does not drive the pads");

    sample_capture_a: assert property ( // see R4
        ((s_q.st == ST_CAP_DR) && (s_q.ir == BSC_IR_SAMPLE))
        |=> (s_q.bsr_sh == $past(pins_s)) && !s_q.drive)
        else $error("sample capture wrong or pads taken over");

    sample_preload_a: assert property ( // see R5
        ((s_q.st == ST_UPD_DR) && (s_q.ir == BSC_IR_SAMPLE))
        |=> (s_q.upd == $past(s_q.bsr_sh[N_OUT-1:0]))
            && (s_q.upd_tog != $past(s_q.upd_tog)))
        else $error("preload did not reach output latches");

    clamp_hold_a: assert property ( // see R6
        ((s_q.ir == BSC_IR_CLAMP) && (s_q.st == ST_SH_DR))
        |=> s_q.drive && $stable(s_q.bsr_sh) && o_tdo == $past(i_tdi))
        else $error("clamp path or pad drive wrong");

    id_first_bit_a: assert property ( // see R9
        id_captured ##1 (s_q.st == ST_SH_DR)
        |-> (s_q.id_sh == id_word) && o_tdo == id_word[0])
        else $error("id code not loaded on capture");

    id_shift_order_a: assert property ( // see R8
        ((s_q.st == ST_SH_DR) && (s_q.ir == BSC_IR_IDCODE))
        |=> s_q.id_sh == {$past(i_tdi), $past(s_q.id_sh[31:1])})
        else $error("id register shifts the wrong way");

    tms_reset_a: assert property ( // see R14
        tms_five |=> s_q.st == ST_TLR)
        else $error("five mode-select highs did not reset");

    reset_ir_a: assert property ( // see R12
        (s_q.st == ST_TLR) |=> s_q.ir == BSC_IR_IDCODE)
        else $error("reset state did not load idcode");

    trst_async_a: assert property ( // see R11
        @(posedge i_tck) disable iff (1'b0)
        !i_trst_n |-> (s_q.st == ST_TLR) && !o_tdo_en)
        else $error("test reset did not force reset state");

    ////////////////////////////////////////////////////////////////////////
    // instruction and data register bookkeeping
    sequence ir_update;
        s_q.st == ST_UPD_IR;
    endsequence

    sequence extest_update;
        (s_q.st == ST_UPD_DR) && (s_q.ir == BSC_IR_EXTEST);
    endsequence

    ir_capture_a: assert property ( // see R1
        (s_q.st == ST_CAP_IR) |=> s_q.ir_sh == BSC_IR_CAPTURE)
        else $error("instruction capture value wrong");

    ir_shift_a: assert property ( // see R1
        (s_q.st == ST_SH_IR)
        |=> s_q.ir_sh == {$past(i_tdi), $past(s_q.ir_sh[BSC_IR_W-1:1])})
        else $error("instruction register shifts the wrong way");

    ir_update_a: assert property ( // see R1
        ir_update |=> s_q.ir == $past(s_q.ir_sh))
        else $error("instruction not taken on update");

    ir_hold_a: assert property ( // see R12
        (s_q.st != ST_UPD_IR) && (s_q.st != ST_TLR) |=> $stable(s_q.ir))
        else $error("instruction changed outside update or reset");

    bypass_capture_a: assert property ( // see R2
        (s_q.st == ST_CAP_DR) |=> !s_q.bp)
        else $error("bypass stage not cleared on capture");

    drive_ir_a: assert property ( // see R6
        s_q.drive == bsc_drives_pins(s_q.ir))
        else $error("pad drive does not follow the instruction");

    update_hold_a: assert property ( // see R5
        (s_q.st != ST_UPD_DR)
        |=> $stable(s_q.upd) && $stable(s_q.upd_tog))
        else $error("output latches moved outside update");

    extest_capture_a: assert property ( // see R3
        ((s_q.st == ST_CAP_DR) && (s_q.ir == BSC_IR_EXTEST))
        |=> s_q.bsr_sh == $past(pins_s))
        else $error("extest did not observe the pads");

    extest_update_a: assert property ( // see R3
        extest_update
        |=> (s_q.upd == $past(s_q.bsr_sh[N_OUT-1:0]))
            && (s_q.upd_tog != $past(s_q.upd_tog)))
        else $error("extest update did not reach output latches");

    id_hold_a: assert property ( // see R8
        (s_q.ir != BSC_IR_IDCODE) |=> $stable(s_q.id_sh))
        else $error("id register moved while not selected");

    bsr_hold_a: assert property ( // see R6
        !bsc_uses_bsr(s_q.ir) |=> $stable(s_q.bsr_sh))
        else $error("boundary register moved while not selected");

    ir_out_a: assert property ( // see R1
        (s_q.st == ST_SH_IR) |-> o_tdo == s_q.ir_sh[0])
        else $error("data out does not show instruction bit");

    bsr_out_a: assert property ( // see R3
        ((s_q.st == ST_SH_DR) && bsc_uses_bsr(s_q.ir))
        |-> o_tdo == s_q.bsr_sh[0])
        else $error("data out does not show boundary bit");

    id_out_a: assert property ( // see R10
        ((s_q.st == ST_SH_DR) && (s_q.ir == BSC_IR_IDCODE))
        |-> o_tdo == s_q.id_sh[0])
        else $error("data out does not show id bit zero");
endmodule // bsc_tap

// file: test/boundary_scan_tap_test.sv
// boundary_scan_tap_test: self-checking bench for the scan port.
// assumes bsc_tester_model drives the test pins on its own clock.
`timescale 1ns/100ps
module boundary_scan_tap_test;
    import bsc_pkg::*;

    typedef struct packed {
        logic [3:0] ir;
        logic [5:0] len;
        logic [31:0] din;
        logic [31:0] dout;
        logic [7:0] pins;
    } bsc_row_type;

    localparam logic [31:0] ID_EXP = {BSC_ID_VER_DEF, BSC_ID_PART_DEF,
        BSC_ID_MAN_DEF, 1'b1};
    // sample preloads 5a, extest drives it and loads c3, clamp keeps c3
    localparam bsc_row_type ROWS [7] = '{
        '{BSC_IR_IDCODE, 6'd32, 32'h0, ID_EXP, 8'h3c},
        '{BSC_IR_BYPASS, 6'd8, 32'ha5, 32'h4a, 8'h3c},
        '{4'h7, 6'd8, 32'ha5, 32'h4a, 8'h3c},
        '{BSC_IR_SAMPLE, 6'd16, 32'h005a, 32'h963c, 8'h3c},
        '{BSC_IR_EXTEST, 6'd16, 32'h00c3, 32'h965a, 8'hc3},
        '{BSC_IR_CLAMP, 6'd8, 32'ha5, 32'h4a, 8'hc3},
        '{BSC_IR_BYPASS, 6'd8, 32'ha5, 32'h4a, 8'h3c}
    };

    logic i_clk;
    logic i_sys_rst;
    logic [7:0] i_pin_in;
    logic [7:0] i_core_out;
    wire logic tck;
    wire logic trst_n;
    wire logic tms;
    wire logic tdi;
    logic o_tdo;
    logic o_tdo_en;
    logic [7:0] o_pin_out;
    int errors;
    int compares;

    ////////////////////////////////////////////////////////////////////////
    bsc_tap #(
        .N_IN(8),
        .N_OUT(8)
    ) i_bsc_tap (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_tck(tck),
        .i_trst_n(trst_n),
        .i_tms(tms),
        .i_tdi(tdi),
        .o_tdo(o_tdo),
        .o_tdo_en(o_tdo_en),
        .i_pin_in(i_pin_in),
        .i_core_out(i_core_out),
        .o_pin_out(o_pin_out)
    );

    bsc_tester_model i_bsc_tester_model (
        .o_tck(tck),
        .o_trst_n(trst_n),
        .o_tms(tms),
        .o_tdi(tdi),
        .i_tdo(o_tdo),
        .i_tdo_en(o_tdo_en)
    );

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wrap_up();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // pads settle a few system clocks after an update; bounded wait
    task automatic wait_pins(input logic [7:0] exp);
        int n;
        n = 0;
        while (o_pin_out !== exp && n < 20) begin
            @(negedge i_clk);
            n++;
        end
        cmp_word({24'h0, o_pin_out}, {24'h0, exp});
        if (n >= 20) begin
            wrap_up();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic q;
        logic e;
        errors = 0;
        compares = 0;
        i_sys_rst = 1'b1;
        i_pin_in = 8'h96;
        i_core_out = 8'h3c;
        repeat (8) @(posedge i_clk);
        cmp_word({24'h0, o_pin_out}, 32'h0);
        i_sys_rst <= 1'b0;
        i_bsc_tester_model.set_trst(1'b1);
        wait_pins(8'h3c);
        // enable moves on the falling edge, first bit is id bit 0
        i_bsc_tester_model.tick(1'b0, 1'b0, q, e);
        i_bsc_tester_model.tick(1'b1, 1'b0, q, e);
        i_bsc_tester_model.tick(1'b0, 1'b0, q, e);
        i_bsc_tester_model.tick(1'b0, 1'b0, q, e);
        cmp_bit(e, 1'b0);
        i_bsc_tester_model.tick(1'b0, 1'b0, q, e);
        cmp_bit(e, 1'b1);
        cmp_bit(q, ID_EXP[0]);
        // test reset mid-shift with the test clock stopped
        i_bsc_tester_model.set_trst(1'b0);
        #1;
        cmp_bit(o_tdo_en, 1'b0);
        // a test clock edge while held must not move the controller
        i_bsc_tester_model.tick(1'b0, 1'b1, q, e);
        cmp_bit(e, 1'b0);
        #300;
        i_bsc_tester_model.set_trst(1'b1);
        i_bsc_tester_model.scan(1'b0, 32, 32'h0, d);
        cmp_word(d, ID_EXP);
        foreach (ROWS[k]) begin
            i_bsc_tester_model.scan(1'b1, 4, {28'h0, ROWS[k].ir}, d);
            cmp_word(d, {28'h0, BSC_IR_CAPTURE});
            repeat (10) @(posedge i_clk);
            i_bsc_tester_model.scan(1'b0, ROWS[k].len, ROWS[k].din, d);
            cmp_word(d, ROWS[k].dout);
            wait_pins(ROWS[k].pins);
        end
        // five mode-select highs reach reset, one more reloads idcode
        i_bsc_tester_model.scan(1'b1, 4, {28'h0, BSC_IR_BYPASS}, d);
        repeat (6) i_bsc_tester_model.tick(1'b1, 1'b0, q, e);
        i_bsc_tester_model.scan(1'b0, 32, 32'h0, d);
        cmp_word(d, ID_EXP);
        // system reset in mid-run clears the pads
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        cmp_word({24'h0, o_pin_out}, 32'h0);
        i_sys_rst <= 1'b0;
        wait_pins(8'h3c);
        wrap_up();
    end

endmodule // boundary_scan_tap_test

// file: test/bsc_tester_model.sv
// bsc_tester_model: board-level tester that drives the scan port pins.
// assumes the bench calls its tasks one at a time from one process.
`timescale 1ns/100ps
module bsc_tester_model (
    output logic o_tck,
    output logic o_trst_n,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo,
    input wire logic i_tdo_en
);

    ////////////////////////////////////////////////////////////////////////
    // port held in test-logic-reset until the bench starts a test
    // reset drops after time zero so the design cannot miss its edge
    initial begin
        o_tck = 1'b0;
        o_trst_n = 1'b1;
        o_tms = 1'b1;
        o_tdi = 1'b0;
        #20;
        o_trst_n = 1'b0;
    end

    task automatic set_trst(input logic v);
        o_trst_n <= v;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // one 160 ns period; tck stands low between calls, never free-running
    task automatic tick(input logic m, input logic d,
        output logic q, output logic e);
        #10;
        o_tms <= m;
        o_tdi <= d;
        #70;
        o_tck = 1'b1;
        q = i_tdo;
        e = i_tdo_en;
        #80;
        o_tck = 1'b0;
    endtask

    // full scan from idle: ir_sel picks the instruction path
    task automatic scan(input logic ir_sel, input int len,
        input logic [31:0] din, output logic [31:0] dout);
        logic q;
        logic e;
        dout = 32'h0;
        tick(1'b0, ~o_tdi, q, e);
        tick(1'b1, ~o_tdi, q, e);
        if (ir_sel) begin
            tick(1'b1, ~o_tdi, q, e);
        end
        tick(1'b0, ~o_tdi, q, e);
        tick(1'b0, ~o_tdi, q, e);
        for (int i = 0; i < len; i++) begin
            tick(i == len - 1, din[i], q, e);
            dout[i] = q;
        end
        tick(1'b1, ~o_tdi, q, e);
        tick(1'b0, ~o_tdi, q, e);
        // data line carries no meaning now: show the inverse, not a hold
        o_tdi <= ~o_tdi;
    endtask

endmodule // bsc_tester_model
